// [design/sdip_pkg.sv]
// Package with constants and carrier types of the serial converter port.
package sdip_pkg;

  // ******************************************************************
  // Word layout and counts
  // ******************************************************************
  localparam int CODE_W = 12;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam int SYNC_W = 5;
  localparam logic [CNT_W-1:0] COUNT_RESET = 5'h00;
  localparam logic [CNT_W-1:0] COUNT_ONE = 5'h01;
  localparam logic [CNT_W-1:0] FRAME_EDGES = 5'h10;
  localparam logic [CNT_W-1:0] LAST_EDGE = 5'h0F;
  localparam logic [CODE_W-1:0] CLEAR_CODE = 12'h000;
  localparam logic [CODE_W-1:0] MID_CODE = 12'h800;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // ******************************************************************
  // Synchroniser bit positions and reset values
  // ******************************************************************
  localparam int SY_LOAD = 0;
  localparam int SY_CLEAR = 1;
  localparam int SY_FORMAT = 2;
  localparam int SY_FRAME = 3;
  localparam int SY_CHAIN = 4;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h0B;

  // ******************************************************************
  // Register map
  // ******************************************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] REG_WORD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h08;
  localparam int ST_AUTO_BIT = 12;
  localparam int ST_CHAIN_BIT = 13;
  localparam int ST_FORMAT_BIT = 14;
  localparam int ST_CLEAR_BIT = 15;
  localparam int CTRL_CLEAR_BIT = 0;
  localparam logic [31:0] DATA_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ******************************************************************
  // Bus carriers
  // ******************************************************************
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } sdip_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sdip_axi_rsp_t;

endpackage : sdip_pkg

// [design/sdip_port.sv]
// Serial input port, converter latch and register slave of the converter.
//
// Functional notes
// - Shift serial input on falling clock edges.
// - Frame sync high restarts the shift logic.
// - Load strobe falling edge updates the latch.
// - Strobe held low in standalone mode: update on sixteenth edge.
// - Clear forces zero code into latch.
// - Format select picks offset or two's complement.
// - Chain enable drives serial output from register.
// - Bipolar zero is mid code or zero.
// - Latch holds twelve bits, drives output.
// - Standalone gating admits only sixteen edges.
// - First four bits ignored, LSB last.
// - Strobe level at frame start picks mode.
// - Chain mode shifts every edge, register MSB out.
module sdip_port
  import sdip_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic serialClk,
  input wire logic frameSync_n,
  input wire logic serial_in,
  input wire logic load_strobe_n,
  input wire logic clear_n,
  input wire logic format_select,
  input wire logic chain_enable,
  output logic serial_out,
  output logic [CODE_W-1:0] latchCode,
  output logic [CODE_W-1:0] converterCode,
  output logic updatePulse,
  input wire sdip_axi_req_t axiReq,
  output sdip_axi_rsp_t axiRsp
);

  // ******************************************************************
  // Declarations
  // ******************************************************************
  logic [CNT_W-1:0] bitCount_reg;
  logic [WORD_W-1:0] shift_reg;
  logic serialOut_reg;
  logic autoMode_reg;
  logic done_reg;
  logic shiftEnable;

  logic [SYNC_W-1:0] pinSync;
  logic doneMeta_reg;
  logic doneSync_reg;
  logic doneSeen_reg;
  logic frameSeen_reg;
  logic loadSeen_reg;
  logic doneRise;
  logic frameEnd;
  logic loadFall;
  logic clearActive;

  logic [WORD_W-1:0] inputWord_reg;
  logic frameAuto_reg;
  logic [CODE_W-1:0] latch_reg;
  logic [CODE_W-1:0] latch_next;
  logic [CODE_W-1:0] converter_reg;
  logic update_reg;
  logic update_next;
  logic softClear_reg;

  logic awHave_reg;
  logic awHave_next;
  logic wHave_reg;
  logic wHave_next;
  logic [ADDR_W-1:0] awAddr_reg;
  logic [31:0] wData_reg;
  logic [3:0] wStrb_reg;
  logic bvalid_reg;
  logic bvalid_next;
  logic [1:0] bresp_reg;
  logic writeFire;
  logic writeOk;
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // ******************************************************************
  // Link domain: gating counter
  // ******************************************************************
  assign shiftEnable = !frameSync_n &&
                       (chain_enable || bitCount_reg != FRAME_EDGES);

  always_ff @(negedge serialClk or posedge frameSync_n) begin
    if (frameSync_n) begin
      bitCount_reg <= COUNT_RESET;
    end else if (shiftEnable && bitCount_reg != FRAME_EDGES) begin
      bitCount_reg <= bitCount_reg + COUNT_ONE;
    end
  end

  // ******************************************************************
  // Link domain: input shift register
  // ******************************************************************
  always_ff @(negedge serialClk) begin
    if (shiftEnable) begin
      shift_reg <= {shift_reg[WORD_W-2:0], serial_in};
    end
  end

  // ******************************************************************
  // Link domain: serial output
  // ******************************************************************
  always_ff @(negedge serialClk or posedge frameSync_n) begin
    if (frameSync_n) begin
      serialOut_reg <= 1'b0;
    end else if (shiftEnable && chain_enable) begin
      serialOut_reg <= shift_reg[WORD_W-2];
    end
  end

  // ******************************************************************
  // Link domain: update mode and word-complete flag
  // ******************************************************************
  always_ff @(negedge serialClk) begin
    if (shiftEnable && bitCount_reg == COUNT_RESET) begin
      autoMode_reg <= ~load_strobe_n;
    end
  end

  always_ff @(negedge serialClk) begin
    if (shiftEnable) begin
      done_reg <= !chain_enable && bitCount_reg == LAST_EDGE;
    end
  end

  // ******************************************************************
  // Crossing into the reference clock domain
  // ******************************************************************
  sdip_sync3 #(
    .WIDTH(SYNC_W),
    .RESET_VAL(SYNC_RESET)
  ) uPinSync (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .asyncIn({chain_enable, frameSync_n, format_select, clear_n,
              load_strobe_n}),
    .syncOut(pinSync)
  );

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      doneMeta_reg <= 1'b0;
      doneSync_reg <= 1'b0;
    end else begin
      doneMeta_reg <= done_reg;
      doneSync_reg <= doneMeta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      doneSeen_reg <= 1'b0;
      frameSeen_reg <= 1'b1;
      loadSeen_reg <= 1'b1;
    end else begin
      doneSeen_reg <= doneSync_reg;
      frameSeen_reg <= pinSync[SY_FRAME];
      loadSeen_reg <= pinSync[SY_LOAD];
    end
  end

  assign doneRise = doneSync_reg && !doneSeen_reg;
  assign frameEnd = pinSync[SY_FRAME] && !frameSeen_reg;
  assign loadFall = !pinSync[SY_LOAD] && loadSeen_reg;
  assign clearActive = !pinSync[SY_CLEAR] || softClear_reg;

  // ******************************************************************
  // Captured input word
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      inputWord_reg <= WORD_RESET;
      frameAuto_reg <= 1'b0;
    end else if (doneRise) begin
      inputWord_reg <= shift_reg;
      frameAuto_reg <= autoMode_reg;
    end else if (frameEnd) begin
      inputWord_reg <= shift_reg;
    end
  end

  // ******************************************************************
  // Converter latch
  // ******************************************************************
  always_comb begin
    latch_next = latch_reg;
    update_next = 1'b0;
    if (clearActive) begin
      latch_next = CLEAR_CODE;
      update_next = latch_reg != CLEAR_CODE;
    end else if (doneRise && autoMode_reg) begin
      latch_next = shift_reg[CODE_W-1:0];
      update_next = 1'b1;
    end else if (loadFall) begin
      latch_next = inputWord_reg[CODE_W-1:0];
      update_next = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      latch_reg <= CLEAR_CODE;
      update_reg <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      update_reg <= update_next;
    end
  end

  // ******************************************************************
  // Code interpretation for the resistor ladder
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      converter_reg <= CLEAR_CODE;
    end else if (pinSync[SY_FORMAT]) begin
      converter_reg <= latch_next ^ MID_CODE;
    end else begin
      converter_reg <= latch_next;
    end
  end

  // ******************************************************************
  // Register bus: write channels
  // ******************************************************************
  assign writeFire = awHave_reg && wHave_reg && !bvalid_reg;
  assign writeOk = awAddr_reg == REG_CTRL;

  always_comb begin
    awHave_next = awHave_reg;
    wHave_next = wHave_reg;
    bvalid_next = bvalid_reg;
    if (axiReq.awvalid && !awHave_reg) begin
      awHave_next = 1'b1;
    end
    if (axiReq.wvalid && !wHave_reg) begin
      wHave_next = 1'b1;
    end
    if (writeFire) begin
      bvalid_next = 1'b1;
    end
    if (bvalid_reg && axiReq.bready) begin
      bvalid_next = 1'b0;
      awHave_next = 1'b0;
      wHave_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      awHave_reg <= 1'b0;
      wHave_reg <= 1'b0;
      bvalid_reg <= 1'b0;
    end else begin
      awHave_reg <= awHave_next;
      wHave_reg <= wHave_next;
      bvalid_reg <= bvalid_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      awAddr_reg <= '0;
      wData_reg <= DATA_RESET;
      wStrb_reg <= '0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (axiReq.awvalid && !awHave_reg) begin
        awAddr_reg <= axiReq.awaddr;
      end
      if (axiReq.wvalid && !wHave_reg) begin
        wData_reg <= axiReq.wdata;
        wStrb_reg <= axiReq.wstrb;
      end
      if (writeFire) begin
        bresp_reg <= writeOk ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ******************************************************************
  // Control register
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      softClear_reg <= DATA_RESET[CTRL_CLEAR_BIT];
    end else if (writeFire && writeOk && wStrb_reg[0]) begin
      softClear_reg <= wData_reg[CTRL_CLEAR_BIT];
    end
  end

  // ******************************************************************
  // Register bus: read channel
  // ******************************************************************
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= DATA_RESET;
      rresp_reg <= RESP_OKAY;
    end else if (rvalid_reg) begin
      if (axiReq.rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end else if (axiReq.arvalid && arready_reg) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= DATA_RESET;
      case (axiReq.araddr)
        REG_STATUS: begin
          rdata_reg[CODE_W-1:0] <= latch_reg;
          rdata_reg[ST_AUTO_BIT] <= frameAuto_reg;
          rdata_reg[ST_CHAIN_BIT] <= pinSync[SY_CHAIN];
          rdata_reg[ST_FORMAT_BIT] <= pinSync[SY_FORMAT];
          rdata_reg[ST_CLEAR_BIT] <= clearActive;
        end
        REG_WORD: begin
          rdata_reg[WORD_W-1:0] <= inputWord_reg;
        end
        REG_CTRL: begin
          rdata_reg[CTRL_CLEAR_BIT] <= softClear_reg;
        end
        default: begin
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end else begin
      arready_reg <= 1'b1;
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  assign serial_out = serialOut_reg;
  assign latchCode = latch_reg;
  assign converterCode = converter_reg;
  assign updatePulse = update_reg;

  assign axiRsp.awready = !awHave_reg;
  assign axiRsp.wready = !wHave_reg;
  assign axiRsp.bvalid = bvalid_reg;
  assign axiRsp.bresp = bresp_reg;
  assign axiRsp.arready = arready_reg;
  assign axiRsp.rvalid = rvalid_reg;
  assign axiRsp.rdata = rdata_reg;
  assign axiRsp.rresp = rresp_reg;

endmodule : sdip_port

// [design/sdip_sync3.sv]
// Three-stage input synchroniser with agreement filter, one per bit.
module sdip_sync3
  import sdip_pkg::*;
#(
  parameter int WIDTH = SYNC_W,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // ******************************************************************
  // Per-bit stages
  // ******************************************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : gBit
      logic stage1_reg;
      logic stage2_reg;
      logic stage3_reg;
      logic out_reg;
      always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
          stage1_reg <= RESET_VAL[i];
          stage2_reg <= RESET_VAL[i];
          stage3_reg <= RESET_VAL[i];
          out_reg <= RESET_VAL[i];
        end else begin
          stage1_reg <= asyncIn[i];
          stage2_reg <= stage1_reg;
          stage3_reg <= stage2_reg;
          // A change counts once the second and third stages agree.
          if (stage2_reg == stage3_reg) begin
            out_reg <= stage3_reg;
          end
        end
      end
      assign syncOut[i] = out_reg;
    end
  endgenerate

endmodule : sdip_sync3

// [testbench/sdip_host_model.sv]
// Host serial port model that sends frames to the converter port.
module sdip_host_model (
  output logic serialClk,
  output logic frameSync_n,
  output logic serial_in,
  input wire logic serial_out,
  output logic [31:0] soutBits
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    serialClk = 1'b1;
    frameSync_n = 1'b0;
    serial_in = 1'b0;
    soutBits = 32'h0000_0000;
    // A rising frame sync clears the gating counter and serial output, which have no reset.
    #20 frameSync_n = 1'b1;
  end
  // The chain output is taken on rising clock edges, in mid bit.
  always @(posedge serialClk)
    soutBits <= {soutBits[30:0], serial_out};
  // Sends n bits MSB first; the clock stands still between frames.
  task automatic send(input logic [31:0] w, input int n);
    frameSync_n = 1'b0;
    #62;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #62 serialClk = 1'b0;
      #63 serialClk = 1'b1;
    end
    #62 frameSync_n = 1'b1;
    serial_in = ~serial_in;
  endtask : send
endmodule : sdip_host_model

// [testbench/sdip_port_monitor.sv]
// Checker of the converter port outputs and its register bus answers.
module sdip_port_monitor
  import sdip_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic frameSync_n,
  input wire logic clear_n,
  input wire logic format_select,
  input wire logic chain_enable,
  input wire logic serial_out,
  input wire logic [CODE_W-1:0] latchCode,
  input wire logic [CODE_W-1:0] converterCode,
  input wire logic updatePulse,
  input wire sdip_axi_req_t axiReq,
  input wire sdip_axi_rsp_t axiRsp
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic awHs;
  logic arHs;
  logic arBad;
  assign awHs = axiReq.awvalid && axiRsp.awready && axiReq.wvalid
    && axiRsp.wready;
  assign arHs = axiReq.arvalid && axiRsp.arready;
  assign arBad = !(axiReq.araddr inside {REG_STATUS, REG_WORD, REG_CTRL});
  clear_zero_a: assert property (
    !clear_n [*8] |-> latchCode == CLEAR_CODE) else $error("latch not clear");
  fmt_map_a: assert property (
    ($stable(latchCode) && $stable(format_select)) [*8] |-> converterCode
    == (format_select ? latchCode ^ MID_CODE : latchCode))
    else $error("converter code wrong");
  latch_pulse_a: assert property (
    !$stable(latchCode) |-> (updatePulse || $past(updatePulse))
    or ##1 updatePulse) else $error("latch changed silently");
  sout_idle_a: assert property (
    frameSync_n || !chain_enable |-> !serial_out)
    else $error("serial output active");
  wr_answer_a: assert property (
    awHs |-> ##[1:2] axiRsp.bvalid) else $error("no write answer");
  wr_refuse_a: assert property (
    awHs && axiReq.awaddr != REG_CTRL |-> ##[1:2] axiRsp.bvalid
    && axiRsp.bresp == RESP_SLVERR) else $error("write not refused");
  wr_busy_a: assert property (
    awHs |=> !axiRsp.awready [*2]) else $error("write ready too soon");
  b_done_a: assert property (
    axiRsp.bvalid && axiReq.bready |=> !axiRsp.bvalid)
    else $error("write answer stuck");
  rd_answer_a: assert property (
    arHs |=> axiRsp.rvalid && !axiRsp.arready) else $error("no read answer");
  rd_bad_a: assert property (
    arHs && arBad |=> axiRsp.rresp == RESP_SLVERR
    && axiRsp.rdata == DATA_RESET) else $error("bad read accepted");
  rd_status_a: assert property (
    arHs && axiReq.araddr == REG_STATUS |=> axiRsp.rdata[11:0]
    == $past(latchCode)) else $error("status code wrong");
  cover property (updatePulse);
  cover property (axiRsp.bvalid && axiRsp.bresp == RESP_SLVERR);
  cover property (chain_enable && !frameSync_n);
endmodule : sdip_port_monitor

bind sdip_port sdip_port_monitor mon (.ref_clk, .reset_n, .frameSync_n,
  .clear_n, .format_select, .chain_enable, .serial_out, .latchCode,
  .converterCode, .updatePulse, .axiReq, .axiRsp);

// [testbench/serial_dac_input_port_tb.sv]
// Self-checking bench of the serial converter port.
module serial_dac_input_port_tb;
  import sdip_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [15:0] word;
    logic fmt;
    logic [11:0] conv;
  } sdip_row_t;
  logic ref_clk = 1'b0;
  logic reset_n, serialClk, frameSync_n, serial_in, load_strobe_n, clear_n;
  logic format_select, chain_enable, serial_out, updatePulse;
  logic [CODE_W-1:0] latchCode, converterCode;
  logic [31:0] soutBits, rdData;
  logic [1:0] resp;
  sdip_axi_req_t axiReq;
  sdip_axi_rsp_t axiRsp;
  int num_errors = 0;
  int cmp_count = 0;
  localparam int LIMIT = 400;
  sdip_row_t rows [4] = '{'{16'hFABC, 1'b0, 12'hABC},
    '{16'h0800, 1'b1, 12'h000}, '{16'h3FFF, 1'b0, 12'hFFF},
    '{16'hC000, 1'b1, 12'h800}};
  always #5 ref_clk = ~ref_clk;
  sdip_port DUT (.ref_clk, .reset_n, .serialClk, .frameSync_n, .serial_in,
    .load_strobe_n, .clear_n, .format_select, .chain_enable, .serial_out,
    .latchCode, .converterCode, .updatePulse, .axiReq, .axiRsp);
  sdip_host_model host (.serialClk, .frameSync_n, .serial_in, .serial_out,
    .soutBits);
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic lost(input int n);
    if (n >= LIMIT) begin
      num_errors++;
      $display("mismatch at %0t: wait ran out", $time);
      stop_test();
    end
  endtask : lost
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= a;
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= d;
    axiReq.bready <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      @(posedge ref_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) break;
    end
    lost(n);
    resp = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] a);
    int n;
    @(posedge ref_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= a;
    axiReq.rready <= 1'b1;
    for (n = 0; n < LIMIT; n++) begin
      @(posedge ref_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) break;
    end
    lost(n);
    rdData = axiRsp.rdata;
    resp = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask : bus_rd
  task automatic wait_upd();
    int n;
    for (n = 0; n < LIMIT; n++) begin
      @(posedge ref_clk);
      if (updatePulse === 1'b1) break;
    end
    lost(n);
    repeat (10) @(posedge ref_clk);
  endtask : wait_upd
  initial begin
    reset_n = 1'b0;
    load_strobe_n = 1'b0;
    clear_n = 1'b1;
    format_select = 1'b0;
    chain_enable = 1'b0;
    axiReq = '0;
    axiReq.wstrb = 4'hF;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(32'(latchCode), 32'h0000_0000);
    chk(32'(converterCode), 32'h0000_0000);
    bus_rd(REG_CTRL);
    chk(rdData, DATA_RESET);
    bus_rd(8'h0C);
    chk(32'(resp), 32'(RESP_SLVERR));
    bus_wr(REG_STATUS, 32'h0000_0FFF);
    chk(32'(resp), 32'(RESP_SLVERR));
    $display("reset test done");
    foreach (rows[i]) begin
      format_select <= rows[i].fmt;
      repeat (8) @(posedge ref_clk);
      fork
        host.send({16'h0000, rows[i].word}, 16);
        wait_upd();
      join
      repeat (10) @(posedge ref_clk);
      chk(32'(latchCode), 32'(rows[i].word[11:0]));
      chk(32'(converterCode), 32'(rows[i].conv));
      bus_rd(REG_STATUS);
      chk(rdData, {17'h0, rows[i].fmt, 1'b0, 1'b1,
        rows[i].word[11:0]});
      bus_rd(REG_WORD);
      chk(rdData, {16'h0000, rows[i].word});
      $display("row %0d done", i);
    end
    load_strobe_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    host.send({12'h000, 16'h5A5C, 4'h3}, 20);
    repeat (10) @(posedge ref_clk);
    chk(32'(latchCode), 32'(rows[3].word[11:0]));
    load_strobe_n <= 1'b0;
    wait_upd();
    chk(32'(latchCode), 32'h0000_0A5C);
    bus_rd(REG_STATUS);
    chk(rdData, 32'h0000_4A5C);
    load_strobe_n <= 1'b1;
    $display("strobe test done");
    bus_wr(REG_CTRL, 32'h0000_0001);
    chk(32'(resp), 32'(RESP_OKAY));
    repeat (8) @(posedge ref_clk);
    chk(32'(latchCode), 32'h0000_0000);
    bus_rd(REG_CTRL);
    chk(rdData, 32'h0000_0001);
    bus_wr(REG_CTRL, 32'h0000_0000);
    load_strobe_n <= 1'b0;
    clear_n <= 1'b0;
    host.send(32'h0000_0123, 16);
    repeat (10) @(posedge ref_clk);
    chk(32'(latchCode), 32'h0000_0000);
    clear_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    chk(32'(latchCode), 32'h0000_0000);
    $display("clear test done");
    load_strobe_n <= 1'b1;
    chain_enable <= 1'b1;
    repeat (8) @(posedge ref_clk);
    host.send(32'h1234_F9E7, 32);
    chk({16'h0000, soutBits[16:1]}, 32'h0000_1234);
    repeat (10) @(posedge ref_clk);
    load_strobe_n <= 1'b0;
    wait_upd();
    chk(32'(latchCode), 32'h0000_09E7);
    load_strobe_n <= 1'b1;
    chain_enable <= 1'b0;
    $display("chain test done");
    reset_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(32'(latchCode), 32'h0000_0000);
    chk(32'(converterCode), 32'(MID_CODE));
    bus_rd(REG_WORD);
    chk(rdData, DATA_RESET);
    $display("mid reset test done");
    stop_test();
  end
endmodule : serial_dac_input_port_tb
